// ===== inc/osw_pkg.sv
// Shared constants, types and helpers of the oscillator switching controller.
package osw_pkg;
    // Source select codes.
    localparam logic [2:0] SRC_FAST_RC       = 3'h0;
    localparam logic [2:0] SRC_FAST_RC_PLL   = 3'h1;
    localparam logic [2:0] SRC_PRIMARY       = 3'h2;
    localparam logic [2:0] SRC_PRIMARY_PLL   = 3'h3;
    localparam logic [2:0] SRC_SEC_XTAL      = 3'h4;
    localparam logic [2:0] SRC_LOW_POWER_RC  = 3'h5;
    localparam logic [2:0] SRC_FAST_RC_DIV16 = 3'h6;
    localparam logic [2:0] SRC_FAST_RC_DIVN  = 3'h7;
    // Physical oscillators, one enable bit each.
    localparam int         OSC_COUNT         = 4;
    localparam logic [1:0] OSC_FAST_RC       = 2'h0;
    localparam logic [1:0] OSC_PRIMARY       = 2'h1;
    localparam logic [1:0] OSC_SEC_XTAL      = 2'h2;
    localparam logic [1:0] OSC_LOW_POWER_RC  = 2'h3;
    // Register addresses.
    localparam logic [2:0] ADDR_CTRL_LO      = 3'h0;
    localparam logic [2:0] ADDR_CTRL_HI      = 3'h1;
    localparam logic [2:0] ADDR_TRIM         = 3'h2;
    localparam logic [2:0] ADDR_UNLOCK       = 3'h3;
    localparam logic [2:0] ADDR_POWER_SAVE   = 3'h4;
    localparam logic [2:0] ADDR_PWR_STATUS   = 3'h5;
    // Control register field positions.
    localparam int         CUR_SRC_LSB       = 12;
    localparam int         NEXT_SRC_LSB      = 8;
    localparam int         LOCK_BIT          = 5;
    localparam int         FAIL_BIT          = 3;
    localparam int         SEC_ON_BIT        = 1;
    localparam int         SWREQ_BIT         = 0;
    localparam int         TRIM_W            = 6;
    // Command and key values.
    localparam logic [15:0] UNLOCK_KEY1      = 16'h0055;
    localparam logic [15:0] UNLOCK_KEY2      = 16'h00AA;
    localparam logic [15:0] PSAVE_SLEEP      = 16'h0000;
    localparam logic [15:0] PSAVE_IDLE       = 16'h0001;
    localparam logic [1:0]  SUBMODE_EC       = 2'h0;
    localparam logic        FUSE_SWITCH_ON   = 1'b0;
    // Timing.
    localparam logic [3:0]  SETTLE_CYCLES    = 4'hA;
    localparam int          CLK_PERIOD_NS    = 8;
    localparam int          FAIL_WINDOW_NS   = 2000;
    localparam int          FAIL_WINDOW_CYC  = FAIL_WINDOW_NS / CLK_PERIOD_NS;

    typedef enum logic [1:0] {SW_IDLE, SW_CHECK, SW_WAIT_READY, SW_SETTLE} osw_sw_t;
    typedef enum logic [1:0] {PM_RUN, PM_IDLE, PM_SLEEP} osw_pm_t;

    function automatic logic [1:0] osw_src_osc(input logic [2:0] src);
        case (src)
            SRC_PRIMARY, SRC_PRIMARY_PLL: return OSC_PRIMARY;
            SRC_SEC_XTAL:                 return OSC_SEC_XTAL;
            SRC_LOW_POWER_RC:             return OSC_LOW_POWER_RC;
            default:                      return OSC_FAST_RC;
        endcase
    endfunction

    function automatic logic osw_uses_pll(input logic [2:0] src);
        return (src == SRC_FAST_RC_PLL) || (src == SRC_PRIMARY_PLL);
    endfunction
endpackage

// ===== inc/osw_aux_if.sv
// Carrier between the controller, its unlock detector and its fail-safe monitor.
interface osw_aux_if;
    logic        wrStb;
    logic [2:0]  wrAddr;
    logic [15:0] wrData;
    logic        armed;
    logic        monEnable;
    logic        monActivity;
    logic        monFail;
    modport ctrl    (output wrStb, wrAddr, wrData, monEnable, monActivity, input armed, monFail);
    modport unlock  (input wrStb, wrAddr, wrData, output armed);
    modport monitor (input monEnable, monActivity, output monFail);
endinterface

// ===== logic/osw_unlock.sv
// Two-key unlock detector guarding the oscillator control bytes.
module osw_unlock (
    input  wire logic  core_clk,
    input  wire logic  reset,
    osw_aux_if.unlock  aux
);
    typedef struct packed {
        logic gotKey1;
        logic armed;
    } osw_unl_state_t;

    osw_unl_state_t st_ff, nxt_st;

    always_comb begin
        nxt_st = st_ff;
        // Any write consumes the unlock, so it covers exactly the next write.
        // unlock then write
        if (aux.wrStb) begin
            nxt_st.gotKey1 = 1'b0;
            nxt_st.armed   = 1'b0;
            if (aux.wrAddr == osw_pkg::ADDR_UNLOCK && aux.wrData == osw_pkg::UNLOCK_KEY1) begin
                nxt_st.gotKey1 = 1'b1;
            end else if (aux.wrAddr == osw_pkg::ADDR_UNLOCK
                         && aux.wrData == osw_pkg::UNLOCK_KEY2 && st_ff.gotKey1) begin
                nxt_st.armed = 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign aux.armed = st_ff.armed;
endmodule // osw_unlock

// ===== logic/osw_fail_monitor.sv
// Fail-safe monitor: flags a source whose activity stops toggling for a window.
module osw_fail_monitor #(
    parameter int WINDOW_CYC = osw_pkg::FAIL_WINDOW_CYC
) (
    input  wire logic  core_clk,
    input  wire logic  reset,
    osw_aux_if.monitor aux
);
    localparam int CW = $clog2(WINDOW_CYC + 1);

    typedef struct packed {
        logic          prev;
        logic [CW-1:0] cnt;
        logic          fail;
    } osw_mon_state_t;

    osw_mon_state_t st_ff, nxt_st;

    always_comb begin
        nxt_st      = st_ff;
        nxt_st.prev = aux.monActivity;
        nxt_st.fail = 1'b0;
        if (!aux.monEnable || aux.monActivity != st_ff.prev) begin
            nxt_st.cnt = '0;
        end else if (st_ff.cnt == CW'(WINDOW_CYC - 1)) begin
            nxt_st.cnt  = '0;
            nxt_st.fail = 1'b1;
        end else begin
            nxt_st.cnt = st_ff.cnt + 1'b1;
        end
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign aux.monFail = st_ff.fail;
endmodule // osw_fail_monitor

// ===== logic/osw_clock_ctrl.sv
// System clock controller: source switching, fail-safe fallback and power save.
module osw_clock_ctrl #(
    parameter int FAIL_WINDOW_CYC = osw_pkg::FAIL_WINDOW_CYC
) (
    input  wire logic         core_clk,
    input  wire logic         reset,
    input  wire logic [2:0]   busAddr,
    input  wire logic [15:0]  busWrData,
    input  wire logic         busWr,
    input  wire logic         busRd,
    output logic      [15:0]  busRdData,
    input  wire logic         switchEnableFuse,
    input  wire logic [2:0]   startupSourceFuse,
    input  wire logic [1:0]   primarySubmode,
    input  wire logic         watchdogEnable,
    input  wire logic [3:0]   oscActivity,
    input  wire logic         crystalTimerDone,
    input  wire logic         pllLocked,
    input  wire logic         wakeIrq,
    input  wire logic         watchdogTimeout,
    output logic      [2:0]   systemClockSel,
    output logic      [3:0]   oscEnable,
    output logic              pllEnable,
    output logic      [5:0]   trimValue,
    output logic              cpuClkEnable,
    output logic              periphClkEnable,
    output logic              clockFailTrap,
    output logic              watchdogClear
);
    typedef struct packed {
        logic [7:0]       syncA;
        logic [7:0]       syncB;
        logic             strapDone;
        logic [2:0]       curSrc;
        logic [2:0]       nxtSrc;
        logic [2:0]       tgtSrc;
        logic             swReq;
        logic             lockFlag;
        logic             failFlag;
        logic             secOn;
        logic [5:0]       trim;
        osw_pkg::osw_sw_t sw;
        osw_pkg::osw_pm_t pm;
        logic [3:0]       settleCnt;
        logic             actPrev;
        logic [15:0]      rdData;
        logic [3:0]       oscEn;
        logic             pllEn;
        logic             cpuEn;
        logic             perEn;
        logic             trap;
        logic             wdogClr;
    } osw_state_t;

    osw_state_t st_ff, nxt_st;
    osw_aux_if  aux ();

    logic       switchOn;
    logic [3:0] actS;
    logic       xtalS, lockS, wakeS, wdogToS;
    logic       tgtCrystal, tgtReady, tgtEdge;
    logic [15:0] ctrlWord;

    assign switchOn = (switchEnableFuse == osw_pkg::FUSE_SWITCH_ON);
    assign actS     = st_ff.syncB[3:0];
    assign xtalS    = st_ff.syncB[4];
    assign lockS    = st_ff.syncB[5];
    assign wakeS    = st_ff.syncB[6];
    assign wdogToS  = st_ff.syncB[7];

    assign aux.wrStb       = busWr;
    assign aux.wrAddr      = busAddr;
    assign aux.wrData      = busWrData;
    // monitor gated by fuse
    // The monitor rests during a switch because the watched source is moving.
    assign aux.monEnable   = switchOn && st_ff.strapDone && st_ff.sw == osw_pkg::SW_IDLE
                             && st_ff.pm != osw_pkg::PM_SLEEP;
    assign aux.monActivity = actS[osw_pkg::osw_src_osc(st_ff.curSrc)];

    osw_unlock u_unlock (
        .core_clk (core_clk),
        .reset    (reset),
        .aux      (aux.unlock)
    );

    osw_fail_monitor #(
        .WINDOW_CYC (FAIL_WINDOW_CYC)
    ) u_monitor (
        .core_clk (core_clk),
        .reset    (reset),
        .aux      (aux.monitor)
    );

    // submode from configuration
    // Only crystal sources need the start-up timer; an external clock does not.
    assign tgtCrystal = (osw_pkg::osw_src_osc(st_ff.tgtSrc) == osw_pkg::OSC_SEC_XTAL)
                        || (osw_pkg::osw_src_osc(st_ff.tgtSrc) == osw_pkg::OSC_PRIMARY
                            && primarySubmode != osw_pkg::SUBMODE_EC);
    assign tgtReady   = (!tgtCrystal || xtalS) && (!osw_pkg::osw_uses_pll(st_ff.tgtSrc) || lockS);
    assign tgtEdge    = actS[osw_pkg::osw_src_osc(st_ff.tgtSrc)] != st_ff.actPrev;

    always_comb begin
        ctrlWord = '0;
        ctrlWord[osw_pkg::CUR_SRC_LSB +: 3]  = st_ff.curSrc;
        ctrlWord[osw_pkg::NEXT_SRC_LSB +: 3] = st_ff.nxtSrc;
        ctrlWord[osw_pkg::LOCK_BIT]          = st_ff.lockFlag;
        ctrlWord[osw_pkg::FAIL_BIT]          = st_ff.failFlag;
        ctrlWord[osw_pkg::SEC_ON_BIT]        = st_ff.secOn;
        ctrlWord[osw_pkg::SWREQ_BIT]         = st_ff.swReq;
    end

    always_comb begin
        nxt_st          = st_ff;
        nxt_st.syncA    = {watchdogTimeout, wakeIrq, pllLocked, crystalTimerDone, oscActivity};
        nxt_st.syncB    = st_ff.syncA;
        nxt_st.trap     = 1'b0;
        nxt_st.wdogClr  = 1'b0;
        nxt_st.rdData   = '0;
        nxt_st.actPrev  = actS[osw_pkg::osw_src_osc(st_ff.tgtSrc)];
        nxt_st.lockFlag = lockS && st_ff.pllEn;

        if (!st_ff.strapDone) begin
            nxt_st.strapDone = 1'b1;
            nxt_st.curSrc    = startupSourceFuse;
            nxt_st.nxtSrc    = startupSourceFuse;
        end

        if (busRd) begin
            case (busAddr)
                osw_pkg::ADDR_CTRL_LO,
                osw_pkg::ADDR_CTRL_HI:    nxt_st.rdData = ctrlWord;
                osw_pkg::ADDR_TRIM:       nxt_st.rdData = {10'h000, st_ff.trim};
                osw_pkg::ADDR_PWR_STATUS: nxt_st.rdData = {14'h0000, st_ff.pm};
                default:                  nxt_st.rdData = '0;
            endcase
        end

        if (busWr) begin
            case (busAddr)
                osw_pkg::ADDR_CTRL_LO: begin
                    if (aux.armed) begin
                        nxt_st.secOn = busWrData[osw_pkg::SEC_ON_BIT];
                        if (switchOn && busWrData[osw_pkg::SWREQ_BIT]) begin
                            nxt_st.swReq = 1'b1;
                        end
                        if (!busWrData[osw_pkg::FAIL_BIT]) begin
                            nxt_st.failFlag = 1'b0;
                        end
                    end
                end
                osw_pkg::ADDR_CTRL_HI: begin
                    if (aux.armed) begin
                        nxt_st.nxtSrc = busWrData[osw_pkg::NEXT_SRC_LSB +: 3];
                    end
                end
                osw_pkg::ADDR_TRIM: begin
                    nxt_st.trim = busWrData[osw_pkg::TRIM_W-1:0];
                end
                osw_pkg::ADDR_POWER_SAVE: begin
                    if (busWrData == osw_pkg::PSAVE_SLEEP) begin
                        nxt_st.pm      = osw_pkg::PM_SLEEP;
                        nxt_st.wdogClr = watchdogEnable;
                    end else if (busWrData == osw_pkg::PSAVE_IDLE) begin
                        nxt_st.pm      = osw_pkg::PM_IDLE;
                        nxt_st.wdogClr = watchdogEnable;
                    end
                end
                default: begin
                end
            endcase
        end

        case (st_ff.sw)
            osw_pkg::SW_IDLE: begin
                if (st_ff.swReq && switchOn && st_ff.pm == osw_pkg::PM_RUN) begin
                    nxt_st.sw = osw_pkg::SW_CHECK;
                end
            end
            osw_pkg::SW_CHECK: begin
                if (st_ff.nxtSrc == st_ff.curSrc) begin
                    nxt_st.swReq = 1'b0;
                    nxt_st.sw    = osw_pkg::SW_IDLE;
                end else begin
                    nxt_st.lockFlag  = 1'b0;
                    nxt_st.failFlag  = 1'b0;
                    nxt_st.tgtSrc    = st_ff.nxtSrc;
                    nxt_st.settleCnt = '0;
                    nxt_st.sw        = osw_pkg::SW_WAIT_READY;
                end
            end
            osw_pkg::SW_WAIT_READY: begin
                if (tgtReady) begin
                    nxt_st.sw = osw_pkg::SW_SETTLE;
                end
            end
            osw_pkg::SW_SETTLE: begin
                // A switch does not finish in Sleep, so the core wakes on the source it slept on.
                // ten new-clock cycles
                if (tgtEdge && st_ff.pm != osw_pkg::PM_SLEEP) begin
                    nxt_st.settleCnt = st_ff.settleCnt + 4'h1;
                    if (st_ff.settleCnt == osw_pkg::SETTLE_CYCLES - 4'h1) begin
                        nxt_st.curSrc = st_ff.tgtSrc;
                        nxt_st.swReq  = 1'b0;
                        nxt_st.sw     = osw_pkg::SW_IDLE;
                    end
                end
            end
            default: nxt_st.sw = osw_pkg::SW_IDLE;
        endcase

        // The failure comes last so that it wins over a software clear.
        // fallback and trap
        if (aux.monFail) begin
            nxt_st.failFlag = 1'b1;
            nxt_st.trap     = 1'b1;
            nxt_st.swReq    = 1'b0;
            nxt_st.sw       = osw_pkg::SW_IDLE;
            nxt_st.curSrc   = osw_pkg::osw_uses_pll(st_ff.curSrc) ? osw_pkg::SRC_FAST_RC_PLL
                                                                  : osw_pkg::SRC_FAST_RC;
        end

        if (st_ff.pm != osw_pkg::PM_RUN && (wakeS || wdogToS)) begin
            nxt_st.pm = osw_pkg::PM_RUN;
        end

        nxt_st.oscEn = '0;
        if (nxt_st.pm != osw_pkg::PM_SLEEP) begin
            nxt_st.oscEn[osw_pkg::osw_src_osc(nxt_st.curSrc)] = 1'b1;
            if (nxt_st.sw != osw_pkg::SW_IDLE) begin
                nxt_st.oscEn[osw_pkg::osw_src_osc(nxt_st.tgtSrc)] = 1'b1;
            end
        end
        if (watchdogEnable || (switchOn && nxt_st.pm != osw_pkg::PM_SLEEP)) begin
            nxt_st.oscEn[osw_pkg::OSC_LOW_POWER_RC] = 1'b1;
        end
        if (nxt_st.secOn) begin
            nxt_st.oscEn[osw_pkg::OSC_SEC_XTAL] = 1'b1;
        end
        nxt_st.pllEn = nxt_st.pm != osw_pkg::PM_SLEEP
                       && (osw_pkg::osw_uses_pll(nxt_st.curSrc)
                           || (nxt_st.sw != osw_pkg::SW_IDLE
                               && osw_pkg::osw_uses_pll(nxt_st.tgtSrc)));
        nxt_st.cpuEn = nxt_st.pm == osw_pkg::PM_RUN;
        nxt_st.perEn = nxt_st.pm != osw_pkg::PM_SLEEP;
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign systemClockSel  = st_ff.curSrc;
    assign oscEnable       = st_ff.oscEn;
    assign pllEnable       = st_ff.pllEn;
    assign trimValue       = st_ff.trim;
    assign cpuClkEnable    = st_ff.cpuEn;
    assign periphClkEnable = st_ff.perEn;
    assign clockFailTrap   = st_ff.trap;
    assign watchdogClear   = st_ff.wdogClr;
    assign busRdData       = st_ff.rdData;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);

    sequence seqLastSettleEdge;
        st_ff.sw == osw_pkg::SW_SETTLE && tgtEdge
            && st_ff.settleCnt == osw_pkg::SETTLE_CYCLES - 4'h1 && !aux.monFail
            && st_ff.pm != osw_pkg::PM_SLEEP;
    endsequence

    a_settle_completes: assert property (seqLastSettleEdge |=> !st_ff.swReq
        && systemClockSel == $past(st_ff.tgtSrc)) else $error("switch did not complete");
    a_redundant_abort: assert property (st_ff.sw == osw_pkg::SW_CHECK
        && st_ff.nxtSrc == st_ff.curSrc |=> !st_ff.swReq && st_ff.sw == osw_pkg::SW_IDLE)
        else $error("redundant switch not abandoned");
    a_start_clears_flags: assert property (st_ff.sw == osw_pkg::SW_CHECK
        && st_ff.nxtSrc != st_ff.curSrc && !aux.monFail |=> !st_ff.lockFlag && !st_ff.failFlag)
        else $error("flags not cleared on switch start");
    a_disabled_no_req: assert property (!switchOn |-> !st_ff.swReq)
        else $error("switch request set while disabled");
    a_trim_write: assert property (busWr && busAddr == osw_pkg::ADDR_TRIM
        |=> trimValue == $past(busWrData[5:0])) else $error("trim write lost");
    a_unlock_guard: assert property (busWr && busAddr == osw_pkg::ADDR_CTRL_HI
        && !aux.armed |=> $stable(st_ff.nxtSrc)) else $error("locked write took effect");
    a_fail_fallback: assert property (aux.monFail |=> clockFailTrap && st_ff.failFlag
        && (systemClockSel == osw_pkg::SRC_FAST_RC
            || systemClockSel == osw_pkg::SRC_FAST_RC_PLL)) else $error("no fail fallback");
    a_sleep_clocks_off: assert property (st_ff.pm == osw_pkg::PM_SLEEP
        |-> !cpuClkEnable && !periphClkEnable && !pllEnable) else $error("clock in sleep");
    a_sleep_same_src: assert property (st_ff.pm == osw_pkg::PM_SLEEP
        && !aux.monFail |=> $stable(systemClockSel)) else $error("source changed in sleep");
    a_wake_restores: assert property (st_ff.pm != osw_pkg::PM_RUN && (wakeS || wdogToS)
        |=> cpuClkEnable && periphClkEnable) else $error("wake did not restore clocks");
    a_sleep_wdt_clear: assert property (busWr && busAddr == osw_pkg::ADDR_POWER_SAVE
        && busWrData == osw_pkg::PSAVE_SLEEP && watchdogEnable
        |=> watchdogClear ##0 oscEnable[osw_pkg::OSC_LOW_POWER_RC])
        else $error("watchdog not cleared for sleep");
endmodule // osw_clock_ctrl

// ===== test/osw_osc_model.sv
// Oscillator, crystal timer and PLL model facing the clock controller.
module osw_osc_model (
    input  wire logic       core_clk,
    input  wire logic [3:0] oscEnable,
    input  wire logic       pllEnable,
    input  wire logic [3:0] oscStall,
    output logic      [3:0] oscActivity,
    output logic            crystalTimerDone,
    output logic            pllLocked
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [4:0] xtalCnt = 5'h00;
    logic [3:0] pllCnt  = 4'h0;
    initial oscActivity = 4'h0;
    // A stalled source freezes as a dead crystal would, so the monitor has something to catch.
    always @(posedge core_clk) begin
        oscActivity <= oscActivity ^ (oscEnable & ~oscStall);
        xtalCnt     <= !oscEnable[1] ? 5'h00 : xtalCnt + {4'h0, !crystalTimerDone};
        pllCnt      <= !pllEnable ? 4'h0 : pllCnt + {3'h0, !pllLocked};
    end
    assign crystalTimerDone = (xtalCnt == 5'h14);
    assign pllLocked        = (pllCnt == 4'hC);
endmodule // osw_osc_model

// ===== test/osc_switch_fail_safe_monitor_power_save_tb_top.sv
// Self-checking bench for the oscillator switching and power save controller.
module osc_switch_fail_safe_monitor_power_save_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic        core_clk          = 1'b0;
    logic        reset             = 1'b1;
    logic [2:0]  busAddr           = 3'h0;
    logic [15:0] busWrData         = 16'h0000;
    logic        busWr             = 1'b0;
    logic        busRd             = 1'b0;
    logic        switchEnableFuse  = 1'b0;
    logic [2:0]  startupSourceFuse = 3'h0;
    logic [1:0]  primarySubmode    = 2'h1;
    logic        watchdogEnable    = 1'b0;
    logic        wakeIrq           = 1'b0;
    logic        watchdogTimeout   = 1'b0;
    logic [3:0]  oscStall          = 4'h0;
    logic [15:0] busRdData;
    logic [3:0]  oscActivity, oscEnable;
    logic [2:0]  systemClockSel;
    logic [5:0]  trimValue;
    logic        crystalTimerDone, pllLocked, pllEnable, cpuClkEnable, periphClkEnable;
    logic        clockFailTrap, watchdogClear, seen;
    int          errors = 0;
    int          checks = 0;
    int          cycles = 0;

    always #4 core_clk = ~core_clk;

    osw_clock_ctrl #(.FAIL_WINDOW_CYC(16)) u_dut (.core_clk, .reset, .busAddr, .busWrData,
        .busWr, .busRd, .busRdData, .switchEnableFuse, .startupSourceFuse,
        .primarySubmode, .watchdogEnable, .oscActivity, .crystalTimerDone, .pllLocked,
        .wakeIrq, .watchdogTimeout, .systemClockSel, .oscEnable, .pllEnable, .trimValue,
        .cpuClkEnable, .periphClkEnable, .clockFailTrap, .watchdogClear);
    osw_osc_model u_osc (.core_clk, .oscEnable, .pllEnable, .oscStall, .oscActivity,
        .crystalTimerDone, .pllLocked);

    task automatic finish_test();
        $display("errors=%0d checks=%0d", errors, checks);
        if (errors == 0 && checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [2:0] a, input logic [15:0] d);
        @(posedge core_clk);
        busAddr   <= a;
        busWrData <= d;
        busWr     <= 1'b1;
        @(posedge core_clk);
        busWr <= 1'b0;
    endtask
    task automatic rdchk(input logic [2:0] a, input logic [15:0] m, input logic [15:0] e);
        @(posedge core_clk);
        busAddr <= a;
        busRd   <= 1'b1;
        @(posedge core_clk);
        busRd <= 1'b0;
        #1 chk(busRdData & m, e);
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    task automatic switch_to(input logic [2:0] s);
        wr(3'h3, 16'h0055);
        wr(3'h3, 16'h00AA);
        wr(3'h1, {5'h00, s, 8'h00});
        wr(3'h3, 16'h0055);
        wr(3'h3, 16'h00AA);
        wr(3'h0, 16'h0001);
    endtask

    // The ceiling sits far above the longest expected sequence of a few hundred cycles.
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            errors++;
            finish_test();
        end
    end

    initial begin
        settle(8);
        reset <= 1'b0;
        settle(3);
        rdchk(3'h0, 16'hFFFF, 16'h0000);
        wr(3'h2, 16'hFFE0);
        rdchk(3'h2, 16'hFFFF, 16'h0020);
        chk({10'h000, trimValue}, 16'h0020);
        wr(3'h1, 16'h0300);
        rdchk(3'h1, 16'hFFFF, 16'h0000);
        switch_to(3'h0);
        settle(6);
        rdchk(3'h0, 16'h7701, 16'h0000);
        switch_to(3'h3);
        wait (systemClockSel === 3'h3);
        settle(2);
        rdchk(3'h0, 16'h772B, 16'h3320);
        chk({11'h000, pllEnable, oscEnable}, 16'h001A);
        oscStall <= 4'h2;
        wait (clockFailTrap === 1'b1);
        #1 chk({15'h0000, clockFailTrap}, 16'h0001);
        settle(1);
        chk({13'h0000, systemClockSel}, 16'h0001);
        rdchk(3'h0, 16'h7008, 16'h1008);
        watchdogEnable <= 1'b1;
        wr(3'h4, 16'h0000);
        #1 seen = watchdogClear;
        repeat (3) begin
            @(posedge core_clk);
            #1 seen |= watchdogClear;
        end
        chk({15'h0000, seen}, 16'h0001);
        chk({9'h000, cpuClkEnable, periphClkEnable, pllEnable, oscEnable}, 16'h0008);
        rdchk(3'h5, 16'hFFFF, 16'h0002);
        wakeIrq <= 1'b1;
        settle(4);
        wakeIrq <= 1'b0;
        chk({12'h000, cpuClkEnable, systemClockSel}, 16'h0009);
        wr(3'h4, 16'h0001);
        settle(3);
        chk({11'h000, cpuClkEnable, periphClkEnable, systemClockSel}, 16'h0009);
        watchdogTimeout <= 1'b1;
        settle(4);
        watchdogTimeout <= 1'b0;
        chk({15'h0000, cpuClkEnable}, 16'h0001);
        switch_to(3'h0);
        wait (systemClockSel === 3'h0);
        settle(2);
        chk({11'h000, pllEnable, oscEnable}, 16'h0009);
        // An external clock needs no start-up timer, so this switch beats the crystal wait.
        oscStall       <= 4'h0;
        primarySubmode <= 2'h0;
        switch_to(3'h2);
        settle(20);
        chk({8'h00, pllEnable, systemClockSel, oscEnable}, 16'h002A);
        reset             <= 1'b1;
        switchEnableFuse  <= 1'b1;
        startupSourceFuse <= 3'h5;
        oscStall          <= 4'h8;
        settle(8);
        reset <= 1'b0;
        settle(3);
        switch_to(3'h2);
        settle(40);
        rdchk(3'h0, 16'h7001, 16'h5000);
        chk({13'h0000, systemClockSel}, 16'h0005);
        finish_test();
    end
endmodule // osc_switch_fail_safe_monitor_power_save_tb_top
